// ==== src/spm_defs.svh ====
// constants for the sonet path/line performance-monitoring counters
// assumes a 100 MHz clock and a one-second strobe from outside
// Notes on behaviour
// - path counters stay frozen unless path monitoring is enabled
// - each B3 parity error adds to the path second violation count, max eight per frame
// - path errored second on any parity error, AIS-P, LOP-P or lower-layer defect
// - path severely errored second at 2400 errors or AIS-P or LOP-P
// - path unavailable after ten severe seconds, available after ten clean seconds
// - path failure count rises once per event of AIS/LOP/UNEQ/TIM failures
// - each REI-L reported error adds to far-end line violation count
// - REI-L errors saturate at 8 x N below OC-48, 255 at OC-48
// - far-end errored second on any reported error or RDI-L
// - far-end severe second when errors reach external K or RDI-L present
// - far-end unavailable after ten severe seconds, until ten clean seconds
// - far-end failure count rises once when RFI-L failure is declared
// - an RFI-L failure spanning an interval boundary counts only where it began; path failure counts ignore interval_tick_in
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH
`define SPM_PATH_MAX_PER_FRAME 4'h8
`define SPM_PATH_SES_THRESH    32'h0000_0960
`define SPM_OC48_MAX_PER_FRAME 8'hff
`define SPM_UAS_RUN            4'ha
`endif

// ==== src/spm_pkg.sv ====
// types shared by the counter block and its availability tracker
package spm_pkg;
  typedef enum logic [0:0] {
    SPM_AVAIL   = 1'b0,
    SPM_UNAVAIL = 1'b1
  } spm_avail_t;
endpackage

// ==== src/spm_avail_if.sv ====
// carries one second's verdict into the availability tracker and its state back
`timescale 1ns/100ps
interface spm_avail_if;
  logic tick;
  logic severe;
  logic unavail;
  modport tracker (input tick, input severe, output unavail);
  modport user (output tick, output severe, input unavail);
endinterface

// ==== src/spm_avail.sv ====
// availability tracker: ten-second run rule on severely errored seconds
// assumes tick is a one-cycle pulse once per second
`timescale 1ns/100ps
`include "spm_defs.svh"
module spm_avail
  import spm_pkg::*;
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // second verdicts
  spm_avail_if.tracker av
);
  spm_avail_t state;
  spm_avail_t next_state;
  logic [3:0] run;
  logic [3:0] next_run;

  always_comb
  begin
    next_state = state;
    next_run   = run;
    if (av.tick)
    begin
      case (state)
        SPM_AVAIL:
        begin
          next_run = av.severe ? run + 4'h1 : 4'h0;
          if (av.severe && run + 4'h1 == `SPM_UAS_RUN)
          begin
            next_state = SPM_UNAVAIL;
            next_run   = 4'h0;
          end
        end
        default:
        begin
          next_run = av.severe ? 4'h0 : run + 4'h1;
          if (!av.severe && run + 4'h1 == `SPM_UAS_RUN)
          begin
            next_state = SPM_AVAIL;
            next_run   = 4'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= SPM_AVAIL;
      run   <= 4'h0;
    end
    else
    begin
      state <= next_state;
      run   <= next_run;
    end
  end

  assign av.unavail = (state == SPM_UNAVAIL);

  a_run_bounded: assert property (@(posedge clk_in) disable iff (rst_in) run < `SPM_UAS_RUN)
    else $error("availability run counter overflowed");
endmodule // spm_avail

// ==== src/spm_counters.sv ====
// performance counters for one sts path and the far-end line
// assumes framer inputs are per-frame pulses synchronous to clk_in
`timescale 1ns/100ps
`include "spm_defs.svh"
module spm_counters
  import spm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // control
  input  wire logic        intermediate_path_monitor_enable_in,
  input  wire logic        second_tick_in,
  input  wire logic        oc48_mode_in,
  input  wire logic [4:0]  sts_n_in,
  input  wire logic [31:0] line_ses_k_in,
  input  wire logic        interval_tick_in,
  // path inputs
  input  wire logic        frame_in,
  input  wire logic [3:0]  b3_errors_in,
  input  wire logic        ais_p_in,
  input  wire logic        lop_p_in,
  input  wire logic        lower_defect_in,
  input  wire logic        uneq_p_fail_in,
  input  wire logic        tim_p_fail_in,
  input  wire logic        ais_p_fail_in,
  input  wire logic        lop_p_fail_in,
  // far-end line inputs
  input  wire logic [7:0]  rei_l_in,
  input  wire logic        rdi_l_in,
  input  wire logic        rfi_l_fail_in,
  // path counters
  output logic [31:0]      path_cv_out,
  output logic [31:0]      path_es_out,
  output logic [31:0]      path_ses_out,
  output logic [31:0]      path_uas_out,
  output logic [31:0]      path_fc_out,
  // far-end line counters
  output logic [31:0]      line_cv_out,
  output logic [31:0]      line_es_out,
  output logic [31:0]      line_ses_out,
  output logic [31:0]      line_uas_out,
  output logic [31:0]      line_fc_out
);
  // ----------------------------------------
  // per-second accumulators
  // ----------------------------------------
  logic [31:0] p_sec_err, next_p_sec_err;
  logic [31:0] l_sec_err, next_l_sec_err;
  logic        p_sec_def, next_p_sec_def;
  logic        p_sec_sev, next_p_sec_sev;
  logic        l_sec_rdi, next_l_sec_rdi;
  logic        p_fail_q, next_p_fail_q;
  logic        l_fail_q, next_l_fail_q;
  logic [31:0] next_path_cv, next_path_es, next_path_ses, next_path_uas, next_path_fc;
  logic [31:0] next_line_cv, next_line_es, next_line_ses, next_line_uas, next_line_fc;
  logic [3:0]  p_add;
  logic [7:0]  l_add;
  logic [7:0]  l_cap;
  logic        p_es, p_ses, l_es, l_ses, p_fail, l_fail;

  spm_avail_if p_av ();
  spm_avail_if l_av ();

  // saturating caps keep a misbehaving framer from inflating counts
  function automatic logic [7:0] sat8(input logic [7:0] v, input logic [7:0] cap);
    sat8 = (v > cap) ? cap : v;
  endfunction

  always_comb
  begin
    l_cap = oc48_mode_in ? `SPM_OC48_MAX_PER_FRAME : {sts_n_in, 3'h0};
    p_add = sat8({4'h0, b3_errors_in}, {4'h0, `SPM_PATH_MAX_PER_FRAME}) > 8'h0f ? 4'h8
          : 4'(sat8({4'h0, b3_errors_in}, {4'h0, `SPM_PATH_MAX_PER_FRAME}));
    l_add = sat8(rei_l_in, l_cap);
    p_fail = ais_p_fail_in | lop_p_fail_in | uneq_p_fail_in | tim_p_fail_in;
    l_fail = rfi_l_fail_in;
    p_es  = (p_sec_err != 32'h0) | p_sec_def;
    p_ses = (p_sec_err >= `SPM_PATH_SES_THRESH) | p_sec_sev;
    l_es  = (l_sec_err != 32'h0) | l_sec_rdi;
    l_ses = (l_sec_err >= line_ses_k_in) | l_sec_rdi;
  end

  assign p_av.tick   = second_tick_in & intermediate_path_monitor_enable_in;
  assign p_av.severe = p_ses;
  assign l_av.tick   = second_tick_in;
  assign l_av.severe = l_ses;

  spm_avail u_path_avail (.clk_in(clk_in), .rst_in(rst_in), .av(p_av));
  spm_avail u_line_avail (.clk_in(clk_in), .rst_in(rst_in), .av(l_av));

  // ----------------------------------------
  // next-state computation
  // ----------------------------------------
  always_comb
  begin
    next_p_sec_err = p_sec_err;
    next_l_sec_err = l_sec_err;
    next_p_sec_def = p_sec_def | ais_p_in | lop_p_in | lower_defect_in;
    next_p_sec_sev = p_sec_sev | ais_p_in | lop_p_in;
    next_l_sec_rdi = l_sec_rdi | rdi_l_in;
    next_p_fail_q  = p_fail;
    next_l_fail_q  = l_fail;
    next_path_cv = path_cv_out;
    next_path_es = path_es_out;
    next_path_ses = path_ses_out;
    next_path_uas = path_uas_out;
    next_path_fc = path_fc_out;
    next_line_cv = line_cv_out;
    next_line_es = line_es_out;
    next_line_ses = line_ses_out;
    next_line_uas = line_uas_out;
    next_line_fc = line_fc_out;
    if (frame_in)
    begin
      next_p_sec_err = p_sec_err + {28'h0, p_add};
      next_l_sec_err = l_sec_err + {24'h0, l_add};
    end
    if (intermediate_path_monitor_enable_in)
    begin
      if (frame_in)
        next_path_cv = path_cv_out + {28'h0, p_add};
      if (p_fail && !p_fail_q)
        next_path_fc = path_fc_out + 32'h1;
      if (second_tick_in)
      begin
        next_path_es  = path_es_out + {31'h0, p_es};
        next_path_ses = path_ses_out + {31'h0, p_ses};
        next_path_uas = path_uas_out + {31'h0, p_av.unavail};
      end
    end
    if (frame_in)
      next_line_cv = line_cv_out + {24'h0, l_add};
    // counted on the rising edge only, so an event straddling a boundary stays where it began
    if (l_fail && !l_fail_q)
      next_line_fc = (interval_tick_in ? 32'h0 : line_fc_out) + 32'h1;
    else if (interval_tick_in)
      next_line_fc = 32'h0;
    if (second_tick_in)
    begin
      next_line_es  = line_es_out + {31'h0, l_es};
      next_line_ses = line_ses_out + {31'h0, l_ses};
      next_line_uas = line_uas_out + {31'h0, l_av.unavail};
      // accumulators restart; this cycle's inputs seed the new second
      next_p_sec_err = frame_in ? {28'h0, p_add} : 32'h0;
      next_l_sec_err = frame_in ? {24'h0, l_add} : 32'h0;
      next_p_sec_def = ais_p_in | lop_p_in | lower_defect_in;
      next_p_sec_sev = ais_p_in | lop_p_in;
      next_l_sec_rdi = rdi_l_in;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      p_sec_err <= 32'h0;
      l_sec_err <= 32'h0;
      p_sec_def <= 1'b0;
      p_sec_sev <= 1'b0;
      l_sec_rdi <= 1'b0;
      p_fail_q  <= 1'b0;
      l_fail_q  <= 1'b0;
      path_cv_out <= 32'h0;
      path_es_out <= 32'h0;
      path_ses_out <= 32'h0;
      path_uas_out <= 32'h0;
      path_fc_out <= 32'h0;
      line_cv_out <= 32'h0;
      line_es_out <= 32'h0;
      line_ses_out <= 32'h0;
      line_uas_out <= 32'h0;
      line_fc_out <= 32'h0;
    end
    else
    begin
      p_sec_err <= next_p_sec_err;
      l_sec_err <= next_l_sec_err;
      p_sec_def <= next_p_sec_def;
      p_sec_sev <= next_p_sec_sev;
      l_sec_rdi <= next_l_sec_rdi;
      p_fail_q  <= next_p_fail_q;
      l_fail_q  <= next_l_fail_q;
      path_cv_out <= next_path_cv;
      path_es_out <= next_path_es;
      path_ses_out <= next_path_ses;
      path_uas_out <= next_path_uas;
      path_fc_out <= next_path_fc;
      line_cv_out <= next_line_cv;
      line_es_out <= next_line_es;
      line_ses_out <= next_line_ses;
      line_uas_out <= next_line_uas;
      line_fc_out <= next_line_fc;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_path_frozen: assert property (@(posedge clk_in) disable iff (rst_in)
    !intermediate_path_monitor_enable_in |=> $stable(path_cv_out) && $stable(path_fc_out))
    else $error("path counters moved while monitoring disabled");
  a_path_cv_step: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> (path_cv_out - $past(path_cv_out)) <= 32'h8)
    else $error("path violation step above eight");
  a_path_es_def: assert property (@(posedge clk_in) disable iff (rst_in)
    intermediate_path_monitor_enable_in && ais_p_in ##1 second_tick_in && intermediate_path_monitor_enable_in
    |=> path_es_out == $past(path_es_out) + 32'h1)
    else $error("defect second not counted errored");
  a_path_ses_thr: assert property (@(posedge clk_in) disable iff (rst_in)
    second_tick_in && intermediate_path_monitor_enable_in && p_sec_err >= 32'h960
    |=> path_ses_out == $past(path_ses_out) + 32'h1)
    else $error("severe path second missed");
  a_path_fc_edge: assert property (@(posedge clk_in) disable iff (rst_in)
    intermediate_path_monitor_enable_in && p_fail && !p_fail_q |=> path_fc_out == $past(path_fc_out) + 32'h1)
    else $error("path failure event not counted");
  a_line_cv_cap: assert property (@(posedge clk_in) disable iff (rst_in)
    frame_in && oc48_mode_in |-> l_add == rei_l_in)
    else $error("oc-48 remote errors wrongly capped");
  a_line_es_rdi: assert property (@(posedge clk_in) disable iff (rst_in)
    rdi_l_in ##1 second_tick_in |=> line_es_out == $past(line_es_out) + 32'h1)
    else $error("rdi second not counted errored");
  a_line_ses_rdi: assert property (@(posedge clk_in) disable iff (rst_in)
    rdi_l_in ##1 second_tick_in |=> line_ses_out == $past(line_ses_out) + 32'h1)
    else $error("rdi second not counted severe");
  a_line_fc_once: assert property (@(posedge clk_in) disable iff (rst_in)
    l_fail && l_fail_q && !interval_tick_in |=> $stable(line_fc_out))
    else $error("standing line failure counted again");
  a_sec_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    second_tick_in && !frame_in |=> p_sec_err == 32'h0 && l_sec_err == 32'h0)
    else $error("second accumulators not cleared");

  c_path_uas: cover property (@(posedge clk_in) p_av.unavail && second_tick_in);
  c_line_uas: cover property (@(posedge clk_in) l_av.unavail && second_tick_in);
  c_line_fail: cover property (@(posedge clk_in) l_fail && !l_fail_q);
  c_fail_span: cover property (@(posedge clk_in) l_fail && l_fail_q && interval_tick_in);
endmodule // spm_counters

// ==== tb/spm_far_end.sv ====
// far-end line terminating equipment: returns per-frame error reports
// assumes the bench asks for a count and pulses frame_in once per frame
`timescale 1ns/100ps
module spm_far_end
  import spm_pkg::*;
(
  // clock and per-frame request
  input  wire logic       clk_in,
  input  wire logic       frame_in,
  input  wire logic       oc48_mode_in,
  input  wire logic [4:0] sts_n_in,
  input  wire logic [7:0] want_in,
  // overhead toward the block
  output logic      [7:0] rei_l_out
);
  logic [7:0] cap;
  logic [7:0] last = 8'h5a;

  assign cap = oc48_mode_in ? 8'hff : {sts_n_in, 3'b000};
  // outside a frame the report is stale, so show its inverse rather than hold it
  assign rei_l_out = frame_in ? ((want_in > cap) ? cap : want_in) : ~last;

  always_ff @(posedge clk_in)
    if (frame_in)
      last <= rei_l_out;
endmodule // spm_far_end

// ==== tb/sonet_path_line_pm_counters_bench.sv ====
// self-checking bench: drivers queue expected counts, a watcher compares them
// assumes counters move within one cycle of their cause
`timescale 1ns/100ps
module sonet_path_line_pm_counters_bench
  import spm_pkg::*;
  ;
  typedef struct {int idx; logic [31:0] val;} spm_note_t;
  logic        clk_in = 0, rst_in = 1, en = 1, tick = 0, oc48 = 0, itick = 0, frame = 0, rdi = 0, rfi = 0;
  logic [2:0]  dv = 3'h0;
  logic [3:0]  pf = 4'h0, b3 = 4'h0;
  logic [4:0]  sts_n = 5'h03;
  logic [7:0]  want = 8'h00, rei;
  logic [31:0] k = 32'h0000_0028;
  logic [31:0] got [10];
  logic [31:0] exp_c [10] = '{default: 32'h0};
  string       nm [10] = '{"path_cv", "path_es", "path_ses", "path_uas", "path_fc",
                           "line_cv", "line_es", "line_ses", "line_uas", "line_fc"};
  spm_note_t   q [$];
  int          fail_count = 0, n_compared = 0;

  spm_counters spm_counters_i (
    .clk_in(clk_in), .rst_in(rst_in), .intermediate_path_monitor_enable_in(en), .second_tick_in(tick),
    .oc48_mode_in(oc48), .sts_n_in(sts_n), .line_ses_k_in(k), .interval_tick_in(itick), .frame_in(frame),
    .b3_errors_in(b3), .ais_p_in(dv[0]), .lop_p_in(dv[1]), .lower_defect_in(dv[2]), .uneq_p_fail_in(pf[2]),
    .tim_p_fail_in(pf[3]), .ais_p_fail_in(pf[0]), .lop_p_fail_in(pf[1]), .rei_l_in(rei), .rdi_l_in(rdi),
    .rfi_l_fail_in(rfi), .path_cv_out(got[0]), .path_es_out(got[1]), .path_ses_out(got[2]),
    .path_uas_out(got[3]), .path_fc_out(got[4]), .line_cv_out(got[5]), .line_es_out(got[6]),
    .line_ses_out(got[7]), .line_uas_out(got[8]), .line_fc_out(got[9]));
  spm_far_end spm_far_end_i (
    .clk_in(clk_in), .frame_in(frame), .oc48_mode_in(oc48), .sts_n_in(sts_n), .want_in(want), .rei_l_out(rei));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic note(input int i);
    q.push_back('{i, exp_c[i]});
  endtask
  task automatic settle(input string name);
    for (int c = 0; c < 40 && q.size() != 0; c++)
      @(negedge clk_in);
    if (q.size() != 0)
    begin
      fail_count++;
      $display("MISMATCH %s pending notes expected 0 seen %0d", name, q.size());
    end
    $display("test %s done", name);
  endtask
  task automatic frm(input logic [3:0] b, input logic [7:0] r);
    @(negedge clk_in);
    frame = 1;
    b3 = b;
    want = r;
    @(negedge clk_in);
    frame = 0;
  endtask
  task automatic sec();
    @(negedge clk_in);
    tick = 1;
    @(negedge clk_in);
    tick = 0;
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
    forever #5 clk_in = ~clk_in;
  // two idle edges let a counter land before it is read
  initial
  begin
    spm_note_t n;
    forever
    begin
      wait (q.size() != 0);
      repeat (2) @(negedge clk_in);
      n = q.pop_front();
      cmp(nm[n.idx], n.val, got[n.idx]);
    end
  end
  initial
  begin
    #500us;
    fail_count++;
    stop_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    int n;
    void'($urandom(32'h63a69505));
    repeat (16) @(negedge clk_in);
    rst_in = 0;
    frm(4'h8, 8'h00);
    exp_c[0] += 8;
    // an over-range count from the framer must still add only eight
    frm(4'hf, 8'h00);
    exp_c[0] += 8;
    for (int i = 0; i < 20; i++)
    begin
      n = $urandom_range(8, 0);
      frm(n[3:0], 8'h00);
      exp_c[0] += n;
    end
    note(0);
    sec();
    exp_c[1]++;
    note(1);
    note(2);
    settle("path_cv");
    for (int s = 299; s <= 300; s++)
    begin
      repeat (s) frm(4'h8, 8'h00);
      sec();
      exp_c[0] += 8 * s;
      exp_c[1]++;
      exp_c[2] += (s == 300);
      note(2);
      note(0);
      settle("path_ses_threshold");
    end
    en = 0;
    frm(4'h5, 8'h00);
    sec();
    note(0);
    note(1);
    settle("path_frozen");
    en = 1;
    sec();
    note(1);
    settle("path_clean");
    for (int d = 0; d < 3; d++)
    begin
      dv[d] = 1;
      @(negedge clk_in);
      dv[d] = 0;
      sec();
      exp_c[1]++;
      exp_c[2] += (d < 2);
      note(1);
      if (d < 2)
        note(2);
      settle("path_defect");
    end
    for (int m = 0; m < 2; m++)
    begin
      oc48 = m[0];
      frm(4'h0, 8'hc8);
      frm(4'h0, 8'hff);
      exp_c[5] += m ? 455 : 48;
    end
    oc48 = 0;
    note(5);
    sec();
    // 503 reported errors pass the threshold of 40, so this second is errored and severe
    exp_c[6]++;
    exp_c[7]++;
    note(6);
    note(7);
    settle("line_cap");
    for (int s = 39; s <= 40; s++)
    begin
      frm(4'h0, 8'h18);
      frm(4'h0, s[7:0] - 8'h18);
      sec();
      exp_c[5] += s;
      exp_c[6]++;
      exp_c[7] += (s == 40);
      note(5);
      note(6);
      note(7);
      settle("line_threshold");
    end
    rdi = 1;
    @(negedge clk_in);
    rdi = 0;
    sec();
    exp_c[6]++;
    exp_c[7]++;
    note(6);
    note(7);
    settle("line_rdi");
    for (int f = 0; f < 4; f++)
    begin
      pf[f] = 1;
      exp_c[4]++;
      note(4);
      settle("path_fail");
      pf[f] = 0;
      @(negedge clk_in);
    end
    pf[0] = 1;
    @(negedge clk_in);
    pf[2] = 1;
    @(negedge clk_in);
    pf[0] = 0;
    exp_c[4]++;
    note(4);
    settle("path_fail_overlap");
    pf = 4'h0;
    rfi = 1;
    exp_c[9] = 1;
    note(9);
    settle("line_fail");
    itick = 1;
    @(negedge clk_in);
    itick = 0;
    exp_c[9] = 0;
    note(9);
    settle("line_fail_boundary");
    rfi = 0;
    @(negedge clk_in);
    rfi = 1;
    exp_c[9] = 1;
    note(9);
    settle("line_fail_again");
    rfi = 0;
    for (int u = 0; u < 2; u++)
    begin
      if (u == 0)
        dv[0] = 1;
      else
        rdi = 1;
      repeat (12) sec();
      dv[0] = 0;
      rdi = 0;
      exp_c[1 + 5 * u] += 12;
      exp_c[2 + 5 * u] += 12;
      exp_c[3 + 5 * u] += 2;
      note(1 + 5 * u);
      note(2 + 5 * u);
      note(3 + 5 * u);
      settle("uas_enter");
      repeat (12) sec();
      // the defect was still up in the last enter tick, so the first leave second is severe too
      exp_c[1 + 5 * u] += 1;
      exp_c[2 + 5 * u] += 1;
      exp_c[3 + 5 * u] += 11;
      note(1 + 5 * u);
      note(2 + 5 * u);
      note(3 + 5 * u);
      settle("uas_leave");
    end
    stop_test();
  end
endmodule // sonet_path_line_pm_counters_bench
